/* File: mmsr_pkg.sv */
package mmsr_pkg;
    // Clock and refresh timing
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned RMS_SHORT_MS = 500;
    localparam int unsigned RMS_LONG_MS = 1000;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_STAT_ONE = 8'h54;
    localparam logic [7:0] IDX_STAT_TWO = 8'h55;
    localparam logic [7:0] IDX_PWR_DOWN = 8'h93;
    localparam logic [7:0] IDX_OP_ONE = 8'h96;
    localparam logic [7:0] IDX_OP_TWO = 8'h97;
    localparam logic [7:0] IDX_OP_THREE = 8'h98;
    localparam logic [7:0] IDX_MASK_ONE = 8'h9a;
    localparam logic [7:0] IDX_MASK_TWO = 8'h9b;
    localparam logic [7:0] IDX_UNLOCK = 8'h9e;
    localparam logic [15:0] UNLOCK_KEY = 16'h5555;
    // Reset values and writable bits
    localparam logic [10:0] PD_RESET = 11'h000;
    localparam logic [23:0] OP_RESET = 24'h000000;
    localparam logic [23:0] MASK_RESET = 24'hffffff;
    localparam logic [23:0] OP1_BITS = 24'hc00000;
    localparam logic [23:0] OP2_BITS = 24'hffffff;
    localparam logic [23:0] OP3_BITS = 24'h03bff0;
    // Field positions
    localparam int PD_VOLT_LSB = 8;
    localparam int PD_CUR_LSB = 2;
    localparam int OP1_FAST_HP = 22;
    localparam int OP1_WAVE_FAST = 23;
    localparam int OP2_RMS_SLOW = 22;
    localparam int OP2_FREQ60 = 23;
    localparam int OP3_ISUM = 4;
    localparam int OP3_PERIOD = 5;
    localparam int OP3_APPARENT = 7;
    localparam int OP3_COMB = 8;
    localparam int OP3_GATE = 9;
    localparam int OP3_SRC = 10;
    localparam int OP3_SUM = 15;
    localparam int OP3_VAR_FULL = 16;
    localparam int OP3_WATT_FUND = 17;
    // Waveform source field LSBs, order VA IA VB IB VC IC IN
    localparam int WS_LSB [7] = '{14, 6, 16, 4, 18, 2, 8};
    localparam logic [3:0] SRC_OFF_LO = 4'h0;
    localparam logic [3:0] SRC_OFF_HI = 4'hf;
    localparam logic [1:0] PERIOD_ALT_A = 2'b11;
    localparam logic [1:0] PERIOD_A = 2'b00;
    // Status word fields
    localparam int S1_ZXTO = 3;
    localparam int S1_SIGN = 6;
    localparam int S1_PEAK = 13;
    localparam int S1_ISUM = 20;
    localparam int S2_REACT = 3;
    localparam int S2_FREACT = 6;
    localparam int S2_COMB = 15;
    localparam int S2_OR_ACT = 17;
    localparam int S2_OR_REACT = 18;
    localparam int S2_OR_FREACT = 19;
    localparam logic [23:0] S1_LIVE = 24'h001fc0;
    // Bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic HRESP_OKAY = 1'b0;

    // Event inputs from the metering datapath
    typedef struct packed {
        logic [2:0] sag;
        logic [2:0] zxTimeout;
        logic [6:0] waveSign;
        logic [6:0] peak;
        logic isumOver;
        logic [2:0] activeSign;
        logic [2:0] reactiveSign;
        logic [2:0] fundReactSign;
        logic combinedActive;
    } mmsr_evt_t;

    // Decoded controls toward the datapath
    typedef struct packed {
        logic [2:0] voltOff;
        logic [3:0] curOff;
        logic fastRmsHighPass;
        logic waveFromFast;
        logic [6:0][1:0] waveSrc;
        logic rmsSlow;
        logic lineFreq60;
        logic isumVsWaveSum;
        logic [1:0] periodPhase;
        logic apparentPowerMethod;
        logic combinedSigned;
        logic pulseOutGate;
        logic [3:0] pulseSourceChoice;
        logic pulseEnergySumMethod;
        logic reactiveFullWave;
        logic activeFundamental;
    } mmsr_ctrl_t;
endpackage

/* File: mmsr_top.sv */
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps
// Summary of operation
// - Eleven-bit power-down word, one switches channel off
// - Voltage C..A at 10..8, currents N..A at 5..2
// - Word one bit 22 routes fast RMS through filter
// - Word one bit 23 picks fast waveform source
// - Word two holds two-bit waveform source per channel
// - Word two bit 22 selects 1000ms RMS refresh
// - Word two bit 23 selects 60Hz line
// - Word three bit 4 picks current-sum comparison
// - Bits 6:5 pick line-period phase, 11 is A
// - Bit 7 picks apparent power method
// - Bit 8 picks signed combined power sum
// - Bit 9 gates both energy pulse pins
// - Bits 13:10 pick pulse source, 0000/1111 off
// - Bit 15 picks pulse energy sum method
// - Bit 16 picks full-wave reactive energy
// - Bit 17 picks fundamental active power
// - Status one bits 0-5 flag dips, timeouts
// - Status one bits 6-12 mirror waveform signs
// - Status one bits 13-20 flag peaks, current sum
// - Status two flags power sign changes, summaries
// - Mask words gate flags onto active-low pins
module mmsr_top
    import mmsr_pkg::*;
#(
    parameter int unsigned RMS_SHORT_CYCLES = RMS_SHORT_MS * CYC_PER_MS,
    parameter int unsigned RMS_LONG_CYCLES = RMS_LONG_MS * CYC_PER_MS,
    parameter int CNT_W = 26
) (
    input wire logic clk_sys,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Datapath side
    input wire mmsr_evt_t events,
    input wire logic pulseReqOne,
    input wire logic pulseReqTwo,
    output mmsr_ctrl_t ctrl,
    output logic rmsUpdateTick,
    output logic energyPulsePinOne,
    output logic energyPulsePinTwo,
    output logic interruptPinOneN,
    output logic interruptPinTwoN
);

    ////////////////////////////////////////////////////////////////
    // Parameter checks

    if (RMS_SHORT_CYCLES < 1 || RMS_LONG_CYCLES < 1 ||
        RMS_LONG_CYCLES > (64'd1 << CNT_W) || CNT_W > 31) begin : g_bad
        $error("mmsr_top: refresh counts do not fit the counter");
    end

    ////////////////////////////////////////////////////////////////
    // Address decode

    // Word index from a byte address
    function automatic logic [7:0] wordIdx(input logic [31:0] a);
        wordIdx = a[9:2];
    endfunction

    // Register state
    logic [10:0] pwrDown_reg;
    logic [23:0] opOne_reg;
    logic [23:0] opTwo_reg;
    logic [23:0] opThree_reg;
    logic [23:0] maskOne_reg;
    logic [23:0] maskTwo_reg;
    logic [15:0] unlock_reg;
    logic [23:0] statOne_reg;
    logic [23:0] statTwo_reg;
    // Data-phase bookkeeping
    logic wrPend_reg;
    logic [7:0] wrIdx_reg;
    logic [31:0] rdata_reg;

    // Address phase accepted this cycle
    wire addrTaken = hsel && hready && htrans == HTRANS_NONSEQ;
    wire [7:0] aIdx = wordIdx(haddr);
    wire rdTaken = addrTaken && !hwrite;
    wire wrTaken = addrTaken && hwrite;
    // Writes land only while unlocked, except those to the unlock register
    wire unlocked = unlock_reg == UNLOCK_KEY;
    wire wrOk = wrPend_reg && unlocked;
    wire wrPd = wrOk && wrIdx_reg == IDX_PWR_DOWN;
    wire wrOp1 = wrOk && wrIdx_reg == IDX_OP_ONE;
    wire wrOp2 = wrOk && wrIdx_reg == IDX_OP_TWO;
    wire wrOp3 = wrOk && wrIdx_reg == IDX_OP_THREE;
    wire wrM1 = wrOk && wrIdx_reg == IDX_MASK_ONE;
    wire wrM2 = wrOk && wrIdx_reg == IDX_MASK_TWO;
    // Unlock register itself is always writable
    wire wrUnl = wrPend_reg && wrIdx_reg == IDX_UNLOCK;
    // Reading a status word clears its sticky flags
    wire clrOne = rdTaken && aIdx == IDX_STAT_ONE;
    wire clrTwo = rdTaken && aIdx == IDX_STAT_TWO;

    ////////////////////////////////////////////////////////////////
    // Status words

    // Raw event vector of status one, signs excluded
    wire [23:0] evtOne = {
        3'b000,
        events.isumOver,
        events.peak,
        7'b0000000,
        events.zxTimeout,
        events.sag
    };
    // Live sign bits, never sticky
    wire [23:0] liveOne = {
        17'h00000,
        events.waveSign
    } << S1_SIGN;
    // Raw event vector of status two
    wire [23:0] evtTwo = {
        4'h0,
        |events.fundReactSign,
        |events.reactiveSign,
        |events.activeSign,
        1'b0,
        events.combinedActive,
        6'h00,
        events.fundReactSign,
        events.reactiveSign,
        events.activeSign
    };
    // A new event wins over the clear of the same cycle
    wire [23:0] statOne_next = (evtOne & ~S1_LIVE) | liveOne |
        (statOne_reg & ~S1_LIVE & ~{24{clrOne}});
    wire [23:0] statTwo_next = evtTwo |
        (statTwo_reg & ~{24{clrTwo}});

    // Status flops
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            statOne_reg <= '0;
            statTwo_reg <= '0;
        end else begin
            statOne_reg <= statOne_next;
            statTwo_reg <= statTwo_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Control registers

    // Bus write data lanes per register
    wire [10:0] pd_next = hwdata[10:0];
    wire [23:0] op1_next = hwdata[23:0] & OP1_BITS;
    wire [23:0] op2_next = hwdata[23:0] & OP2_BITS;
    wire [23:0] op3_next = hwdata[23:0] & OP3_BITS;

    // Software-written registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pwrDown_reg <= PD_RESET;
            opOne_reg <= OP_RESET;
            opTwo_reg <= OP_RESET;
            opThree_reg <= OP_RESET;
            maskOne_reg <= MASK_RESET;
            maskTwo_reg <= MASK_RESET;
            unlock_reg <= '0;
        end else begin
            // All eleven bits stored, reserved ones too
            if (wrPd) pwrDown_reg <= pd_next;
            if (wrOp1) opOne_reg <= op1_next;
            if (wrOp2) opTwo_reg <= op2_next;
            if (wrOp3) opThree_reg <= op3_next;
            if (wrM1) maskOne_reg <= hwdata[23:0];
            if (wrM2) maskTwo_reg <= hwdata[23:0];
            if (wrUnl) unlock_reg <= hwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////
    // Bus slave

    // Read selection at the address phase
    logic [31:0] rdSel;
    always_comb begin
        case (aIdx)
            IDX_STAT_ONE: rdSel = {8'h00, statOne_reg};
            IDX_STAT_TWO: rdSel = {8'h00, statTwo_reg};
            IDX_PWR_DOWN: rdSel = {21'h000000, pwrDown_reg};
            IDX_OP_ONE: rdSel = {8'h00, opOne_reg};
            IDX_OP_TWO: rdSel = {8'h00, opTwo_reg};
            IDX_OP_THREE: rdSel = {8'h00, opThree_reg};
            IDX_MASK_ONE: rdSel = {8'h00, maskOne_reg};
            IDX_MASK_TWO: rdSel = {8'h00, maskTwo_reg};
            IDX_UNLOCK: rdSel = {16'h0000, unlock_reg};
            // Unmapped words read as zero
            default: rdSel = 32'h00000000;
        endcase
    end

    // Address-phase capture and read data
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wrPend_reg <= 1'b0;
            wrIdx_reg <= '0;
            rdata_reg <= '0;
        end else begin
            wrPend_reg <= wrTaken;
            if (addrTaken) wrIdx_reg <= aIdx;
            if (rdTaken) rdata_reg <= rdSel;
        end
    end

    // Zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
    assign hrdata = rdata_reg;

    ////////////////////////////////////////////////////////////////
    // Control decode

    // Waveform source per channel
    for (genvar c = 0; c < 7; c++) begin : g_ws
        assign ctrl.waveSrc[c] = opTwo_reg[WS_LSB[c] +: 2];
    end

    // Line period channel, code 11 folds onto A
    wire [1:0] perRaw = opThree_reg[OP3_PERIOD +: 2];
    wire [1:0] perPhase = (perRaw == PERIOD_ALT_A) ?
        PERIOD_A : perRaw;
    wire [3:0] srcSel = opThree_reg[OP3_SRC +: 4];
    // Pins run only with gate on and a live source
    wire pulsesOn = opThree_reg[OP3_GATE] &&
        srcSel != SRC_OFF_LO && srcSel != SRC_OFF_HI;

    assign ctrl.voltOff = pwrDown_reg[PD_VOLT_LSB +: 3];
    assign ctrl.curOff = pwrDown_reg[PD_CUR_LSB +: 4];
    assign ctrl.fastRmsHighPass = opOne_reg[OP1_FAST_HP];
    assign ctrl.waveFromFast = opOne_reg[OP1_WAVE_FAST];
    assign ctrl.rmsSlow = opTwo_reg[OP2_RMS_SLOW];
    assign ctrl.lineFreq60 = opTwo_reg[OP2_FREQ60];
    assign ctrl.isumVsWaveSum = opThree_reg[OP3_ISUM];
    assign ctrl.periodPhase = perPhase;
    assign ctrl.apparentPowerMethod = opThree_reg[OP3_APPARENT];
    assign ctrl.combinedSigned = opThree_reg[OP3_COMB];
    assign ctrl.pulseOutGate = opThree_reg[OP3_GATE];
    assign ctrl.pulseSourceChoice = srcSel;
    assign ctrl.pulseEnergySumMethod = opThree_reg[OP3_SUM];
    assign ctrl.reactiveFullWave = opThree_reg[OP3_VAR_FULL];
    assign ctrl.activeFundamental = opThree_reg[OP3_WATT_FUND];

    ////////////////////////////////////////////////////////////////
    // RMS refresh timer

    logic [CNT_W-1:0] rmsCnt_reg;
    logic tick_reg;
    wire [CNT_W-1:0] rmsLimit = opTwo_reg[OP2_RMS_SLOW] ?
        CNT_W'(RMS_LONG_CYCLES - 1) :
        CNT_W'(RMS_SHORT_CYCLES - 1);
    wire rmsWrap = rmsCnt_reg >= rmsLimit;

    // Free-running interval counter
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rmsCnt_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            rmsCnt_reg <= rmsWrap ? '0 : rmsCnt_reg + 1'b1;
            tick_reg <= rmsWrap;
        end
    end
    assign rmsUpdateTick = tick_reg;

    ////////////////////////////////////////////////////////////////
    // Pulse pins and interrupt pins

    logic pinOne_reg;
    logic pinTwo_reg;
    logic irqOneN_reg;
    logic irqTwoN_reg;
    // A one in the mask blocks its flag
    wire anyOne = |(statOne_reg & ~maskOne_reg);
    wire anyTwo = |(statTwo_reg & ~maskTwo_reg);

    // Registered pin drivers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pinOne_reg <= 1'b0;
            pinTwo_reg <= 1'b0;
            irqOneN_reg <= 1'b1;
            irqTwoN_reg <= 1'b1;
        end else begin
            pinOne_reg <= pulseReqOne && pulsesOn;
            pinTwo_reg <= pulseReqTwo && pulsesOn;
            // Pins pulled low while an unmasked flag stands
            irqOneN_reg <= !anyOne;
            irqTwoN_reg <= !anyTwo;
        end
    end
    assign energyPulsePinOne = pinOne_reg;
    assign energyPulsePinTwo = pinTwo_reg;
    assign interruptPinOneN = irqOneN_reg;
    assign interruptPinTwoN = irqTwoN_reg;

endmodule // mmsr_top

/* File: mmsr_top_asserts.sv */
`timescale 1ns/1ps
module mmsr_top_asserts
    import mmsr_pkg::*;
#(
    parameter int unsigned RMS_SHORT_CYCLES = 10,
    parameter int unsigned RMS_LONG_CYCLES = 20
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic pulseReqOne,
    input wire logic pulseReqTwo,
    input wire mmsr_ctrl_t ctrl,
    input wire logic rmsUpdateTick,
    input wire logic energyPulsePinOne,
    input wire logic energyPulsePinTwo
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    // Pulse source live: gate open and code not one of the two off codes
    wire logic srcOn = ctrl.pulseOutGate && ctrl.pulseSourceChoice != SRC_OFF_LO
        && ctrl.pulseSourceChoice != SRC_OFF_HI;
    // Write address phase taken this cycle
    wire logic wrTake = hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
    wire logic [31:0] tickGoal = ctrl.rmsSlow ? RMS_LONG_CYCLES : RMS_SHORT_CYCLES;
    logic [31:0] tickCnt_reg; // Cycles since last tick
    logic tickSeen_reg; // A first tick has been seen
    logic modeChg_reg; // Interval changed since last tick
    logic slowPrev_reg; // Interval choice one cycle ago
    // Tick spacing bookkeeping
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tickCnt_reg <= '0;
            tickSeen_reg <= 1'b0;
            modeChg_reg <= 1'b0;
            slowPrev_reg <= 1'b0;
        end else begin
            tickCnt_reg <= rmsUpdateTick ? '0 : tickCnt_reg + 32'h1;
            tickSeen_reg <= tickSeen_reg | rmsUpdateTick;
            modeChg_reg <= !rmsUpdateTick && (modeChg_reg || ctrl.rmsSlow != slowPrev_reg);
            slowPrev_reg <= ctrl.rmsSlow;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Tick falls and stays low for a while
    sequence s_tick_quiet;
        ##1 !rmsUpdateTick [*8];
    endsequence
    a_pin_one: assert property (energyPulsePinOne == $past(pulseReqOne && srcOn))
        else $error("pulse pin one wrong");
    a_pin_two: assert property (energyPulsePinTwo == $past(pulseReqTwo && srcOn))
        else $error("pulse pin two wrong");
    a_bus_okay: assert property (hreadyout && hresp == HRESP_OKAY)
        else $error("bus not ready or not okay");
    a_upper_zero: assert property (hrdata[31:24] == 8'h00)
        else $error("read data above register width");
    a_period_map: assert property (ctrl.periodPhase != PERIOD_ALT_A)
        else $error("period phase code not folded to A");
    a_ctrl_hold: assert property (!$stable(ctrl) |-> $past(wrTake, 2))
        else $error("controls changed without a write");
    a_tick_space: assert property (tickSeen_reg && !modeChg_reg && ctrl.rmsSlow == slowPrev_reg
        |-> rmsUpdateTick == (tickCnt_reg == tickGoal - 32'h1))
        else $error("refresh tick spacing wrong");
    a_tick_pulse: assert property (rmsUpdateTick |-> s_tick_quiet)
        else $error("refresh tick not a lone pulse");
endmodule // mmsr_top_asserts

/* File: metering_mode_status_regs_tb.sv */
`timescale 1ns/1ps
module metering_mode_status_regs_tb
    import mmsr_pkg::*;
;
    typedef struct packed {logic w; logic [7:0] idx; logic [31:0] d; logic [31:0] q;} mmsr_row_t;
    logic clk_sys = 0, rst = 1, hsel = 0, hwrite = 0, pulseReqOne = 0, pulseReqTwo = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2; // Word transfers only
    wire logic hready, hreadyout, hresp, rmsUpdateTick, pinOne, pinTwo, irqOneN, irqTwoN;
    mmsr_evt_t evt = '0, e;
    mmsr_ctrl_t ctrl;
    int error_cnt = 0, samples_checked = 0;
    mmsr_row_t rows [17] = '{
        '{0, IDX_PWR_DOWN, 0, 0}, '{0, IDX_OP_ONE, 0, 0}, '{0, IDX_OP_TWO, 0, 0},
        '{0, IDX_OP_THREE, 0, 0}, '{0, IDX_MASK_ONE, 0, 32'hffffff},
        '{0, IDX_MASK_TWO, 0, 32'hffffff}, '{0, IDX_UNLOCK, 0, 0},
        '{0, IDX_STAT_ONE, 0, 0}, '{0, IDX_STAT_TWO, 0, 0},
        '{1, IDX_PWR_DOWN, '1, 0}, '{1, IDX_UNLOCK, 32'h5555, 32'h5555},
        '{1, IDX_PWR_DOWN, '1, 32'h7ff}, '{1, IDX_OP_ONE, '1, 32'hc00000},
        '{1, IDX_OP_TWO, '1, 32'hffffff}, '{1, IDX_OP_THREE, '1, 32'h03bff0},
        '{1, IDX_STAT_ONE, '1, 0}, '{1, IDX_MASK_ONE, 32'hfffffe, 32'hfffffe}};
    assign hready = hreadyout; // Single slave drives bus ready
    mmsr_top #(.RMS_SHORT_CYCLES(10), .RMS_LONG_CYCLES(20)) dut (.clk_sys(clk_sys), .rst(rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .events(evt), .pulseReqOne(pulseReqOne), .pulseReqTwo(pulseReqTwo),
        .ctrl(ctrl), .rmsUpdateTick(rmsUpdateTick), .energyPulsePinOne(pinOne),
        .energyPulsePinTwo(pinTwo), .interruptPinOneN(irqOneN), .interruptPinTwoN(irqTwoN));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    always #10 clk_sys = ~clk_sys;
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        test_done();
    end
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One bus transfer: address phase, then data phase
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= w;
        do @(posedge clk_sys); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk_sys); while (hready !== 1'b1);
        q = hrdata;
        // Let the write land before the caller looks at the controls
        #1;
    endtask
    // Cycles between two refresh ticks
    task automatic tick_gap(input int exp);
        int n;
        n = 0;
        while (rmsUpdateTick !== 1'b1) begin @(posedge clk_sys); #1; end
        do begin @(posedge clk_sys); #1; n++; end while (rmsUpdateTick !== 1'b1);
        check(32'(n), 32'(exp));
    endtask
    // Request one energy pulse on both pins
    task automatic pulse_chk(input logic exp);
        @(posedge clk_sys);
        pulseReqOne <= 1'b1;
        pulseReqTwo <= 1'b1;
        @(posedge clk_sys);
        pulseReqOne <= 1'b0;
        pulseReqTwo <= 1'b0;
        #1;
        check({pinOne, pinTwo}, {exp, exp});
    endtask
    task automatic test_done();
        if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        check(32'(|ctrl), 0);
        check({pinOne, pinTwo, irqOneN, irqTwoN}, 32'h3);
        tick_gap(10);
        foreach (rows[i]) begin
            if (rows[i].w) xfer(1'b1, rows[i].idx, rows[i].d);
            xfer(1'b0, rows[i].idx, 0);
            check(q, rows[i].q);
        end
        xfer(1'b0, 8'h40, 0);
        check(q, 0);
        xfer(1'b1, IDX_PWR_DOWN, 32'h504);
        check({ctrl.voltOff, ctrl.curOff}, 32'h51);
        xfer(1'b1, IDX_OP_ONE, 32'h400000);
        check({ctrl.fastRmsHighPass, ctrl.waveFromFast}, 32'h2);
        xfer(1'b1, IDX_OP_TWO, 32'hc0c004);
        check({ctrl.waveSrc[0], ctrl.waveSrc[5], ctrl.rmsSlow, ctrl.lineFreq60}, 32'h37);
        tick_gap(20);
        xfer(1'b1, IDX_OP_THREE, 32'h0293f0);
        check({ctrl.isumVsWaveSum, ctrl.periodPhase, ctrl.apparentPowerMethod,
            ctrl.combinedSigned, ctrl.pulseOutGate, ctrl.pulseSourceChoice,
            ctrl.pulseEnergySumMethod, ctrl.reactiveFullWave, ctrl.activeFundamental},
            32'h13a5);
        for (int c = 0; c < 16; c++) begin
            xfer(1'b1, IDX_OP_THREE, 32'h200 | (32'(c) << 10));
            pulse_chk(c != 0 && c != 15);
        end
        xfer(1'b1, IDX_OP_THREE, 32'h1000);
        pulse_chk(1'b0);
        // Unmask phase B active sign change so the second pin can fall
        xfer(1'b1, IDX_MASK_TWO, 32'hfffffd);
        // Short events: they must stick until the status word is read
        e = '0;
        e.waveSign = 7'h55;
        e.sag = 3'b001;
        e.zxTimeout = 3'b100;
        e.peak = 7'h40;
        e.isumOver = 1'b1;
        e.activeSign = 3'b010;
        e.reactiveSign = 3'b100;
        e.fundReactSign = 3'b001;
        e.combinedActive = 1'b1;
        @(posedge clk_sys);
        evt <= e;
        @(posedge clk_sys);
        evt <= '{waveSign: 7'h55, default: '0};
        repeat (3) @(posedge clk_sys);
        #1;
        check({irqOneN, irqTwoN}, 32'h0);
        xfer(1'b0, IDX_STAT_ONE, 0);
        check(q, 32'h181561);
        xfer(1'b0, IDX_STAT_ONE, 0);
        check(q, 32'h001540);
        xfer(1'b0, IDX_STAT_TWO, 0);
        check(q, 32'h0e8062);
        repeat (2) @(posedge clk_sys);
        #1;
        check({irqOneN, irqTwoN}, 32'h3);
        xfer(1'b1, IDX_UNLOCK, 0);
        xfer(1'b1, IDX_PWR_DOWN, 0);
        xfer(1'b0, IDX_PWR_DOWN, 0);
        check(q, 32'h504);
        test_done();
    end
endmodule // metering_mode_status_regs_tb
bind mmsr_top mmsr_top_asserts #(.RMS_SHORT_CYCLES(RMS_SHORT_CYCLES),
    .RMS_LONG_CYCLES(RMS_LONG_CYCLES)) chk (.clk_sys(clk_sys), .rst(rst), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pulseReqOne(pulseReqOne), .pulseReqTwo(pulseReqTwo),
    .ctrl(ctrl), .rmsUpdateTick(rmsUpdateTick), .energyPulsePinOne(energyPulsePinOne),
    .energyPulsePinTwo(energyPulsePinTwo));
